// ===== src/pwg_pkg.sv
// shared constants for the pwm generator with capture
package pwg_pkg;
	localparam int CNT_W = 16;
	localparam int NCH   = 8;
	localparam int NPR   = 4;
	localparam int AW    = 8;
	// register byte offsets
	localparam logic [7:0] OFS_PSC  = 8'h00;
	localparam logic [7:0] OFS_CSEL = 8'h04;
	localparam logic [7:0] OFS_WCR  = 8'h08;
	localparam logic [7:0] OFS_DT   = 8'h0C;
	localparam logic [7:0] OFS_PRD  = 8'h10;
	localparam logic [7:0] OFS_CMP  = 8'h30;
	localparam logic [7:0] OFS_CNT  = 8'h50;
	localparam logic [7:0] OFS_PIE  = 8'h70;
	localparam logic [7:0] OFS_WAVE_IRQ_INDICATION = 8'h74;
	localparam logic [7:0] OFS_CCR  = 8'h78;
	localparam logic [7:0] OFS_RLAT = 8'h88;
	localparam logic [7:0] OFS_FLAT = 8'hA8;
	// field positions
	localparam int WCR_EN   = 0;
	localparam int WCR_AUTO = 8;
	localparam int WCR_DZ   = 16;
	localparam int CCR_CEN  = 0;
	localparam int CCR_RIE  = 1;
	localparam int CCR_FIE  = 2;
	localparam int CCR_FLG  = 4;
	localparam int CCR_HALF = 16;
	localparam int WAVE_IRQ_INDICATION_CAP = 8;
	localparam int CSEL_W   = 3;
	localparam int CSEL_ST  = 4;
	localparam logic [2:0] CSEL_MAX = 3'h4;
	localparam logic [3:0] DIV_W0   = 4'h0;
	localparam logic [7:0] PSC_RST  = 8'h00;
	localparam logic [7:0] DT_RST   = 8'h00;
	localparam logic [15:0] VAL_RST = 16'h0000;
endpackage : pwg_pkg

// ===== src/pwg_timer.sv
// one channel timer: double-buffered down counter, comparator and output
`timescale 1ns/10ps
module pwg_timer #(
	parameter int W = pwg_pkg::CNT_W
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         en_i,
	input  wire logic         tick_i,
	input  wire logic         auto_i,
	input  wire logic         cap_rld_i,
	input  wire logic [W-1:0] prd_i,
	input  wire logic [W-1:0] cmp_i,
	output logic      [W-1:0] cnt_o,
	output logic              zero_o,
	output logic              wave_o
);
	import pwg_pkg::*;
	logic         en_q;
	logic         run_q;
	logic [W-1:0] cnt_q;
	logic [W-1:0] prd_q;
	logic [W-1:0] cmp_q;
	logic         start;
	logic         hit;

	assign start  = en_i & ~en_q;
	assign hit    = run_q & tick_i & (cnt_q == '0);
	assign zero_o = hit;
	assign cnt_o  = cnt_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_q <= 1'b0;
			cnt_q <= '0;
			prd_q <= '0;
			cmp_q <= '0;
		end else if (!en_i) begin
			run_q <= 1'b0;
		end else if (start) begin
			run_q <= 1'b1;
			cnt_q <= prd_i;
			prd_q <= prd_i;
			cmp_q <= cmp_i;
		end else if (hit) begin
			// buffers move to the active copies only at start and at zero: no mid-period glitch
			prd_q <= prd_i;
			cmp_q <= cmp_i;
			if (auto_i) begin
				cnt_q <= prd_i;
			end else begin
				run_q <= 1'b0;
			end
		end else if (cap_rld_i) begin
			cnt_q <= prd_q;
		end else if (run_q && tick_i) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wave_o <= 1'b0;
		end else if (!en_i || start || hit) begin
			wave_o <= 1'b0;
		end else if (run_q && cnt_q == cmp_q) begin
			wave_o <= 1'b1;
		end
	end

	a_oneshot_halt: assert property (@(posedge clk_i) disable iff (!rstn_i)
		hit && !auto_i && en_i |=> !run_q && cnt_q == '0)
		else $error("one-shot counter did not halt at zero");
	a_auto_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
		hit && auto_i && en_i |=> run_q && cnt_q == $past(prd_i))
		else $error("auto-reload did not load the period buffer");
	a_match_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
		en_i && run_q && !start && !hit && cnt_q == cmp_q |=> wave_o)
		else $error("output not high on compare match");
	a_no_count_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!en_i ##1 !en_i |-> $stable(cnt_q))
		else $error("counter moved while channel disabled");
endmodule : pwg_timer

// ===== src/pwg_top.sv
// pwm generator with capture: registers, clocking, dead zone, capture, flags
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module pwg_top #(
	parameter int NCH = pwg_pkg::NCH,
	parameter int W   = pwg_pkg::CNT_W
) (
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic [pwg_pkg::AW-1:0] addr_i,
	input  wire logic [31:0]            wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [31:0]            rdata_o,
	input  wire logic [NCH-1:0]         cap_i,
	output logic      [NCH-1:0]         wave_o,
	output logic      [NCH-1:0]         wave_oe_o,
	output logic                        irq_o
);
	import pwg_pkg::*;
	localparam int NP = NCH / 2;

	if (NCH != 8 || W != 16) begin : g_chk
		$error("pwg_top serves eight 16-bit channels only");
	end

	logic [NP-1:0][7:0]         psc_q;
	logic [NP-1:0][7:0]         pcnt_q;
	logic [NP-1:0]              ptick;
	logic [NCH-1:0][CSEL_W-1:0] csel_q;
	logic [NCH-1:0]             en_q;
	logic [NCH-1:0]             auto_q;
	logic [NP-1:0]              dz_q;
	logic [NP-1:0][7:0]         dt_q;
	logic [NCH-1:0][W-1:0]      prd_q;
	logic [NCH-1:0][W-1:0]      cmp_q;
	logic [NCH-1:0]             pie_q;
	logic [NCH-1:0]             pflag_q;
	logic [NCH-1:0]             cen_q;
	logic [NCH-1:0]             rie_q;
	logic [NCH-1:0]             fie_q;
	logic [NCH-1:0]             cflag_q;
	logic [NCH-1:0][W-1:0]      rlat_q;
	logic [NCH-1:0][W-1:0]      flat_q;
	logic [NCH-1:0][W-1:0]      cnt;
	logic [NCH-1:0]             zero;
	logic [NCH-1:0]             raw;
	logic [NCH-1:0]             tick;
	logic [NCH-1:0]             cap_rld;
	logic [NCH-1:0]             c1_q;
	logic [NCH-1:0]             c2_q;
	logic [NCH-1:0]             c3_q;
	logic [NCH-1:0]             rise;
	logic [NCH-1:0]             fall;
	logic [NCH-1:0]             dzo;
	logic [NCH-1:0][3:0]        dv_q;
	logic [31:0]                rd_d;

	// prescaler per generator: tick every psc+1 clocks
	generate
		for (genvar p = 0; p < NP; p++) begin : g_pair
			logic       base_q;
			logic [7:0] dzc_q;
			assign ptick[p] = (pcnt_q[p] == psc_q[p]);
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pcnt_q[p] <= PSC_RST;
				end else if (ptick[p]) begin
					pcnt_q[p] <= PSC_RST;
				end else begin
					pcnt_q[p] <= pcnt_q[p] + 8'h01;
				end
			end
			// dead zone: both outputs low for dt prescaled ticks after each edge of the
			// even wave, so the pair never overlaps high; the pair lags the timer by a clock
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					base_q <= 1'b0;
					dzc_q  <= DT_RST;
				end else begin
					base_q <= raw[2*p];
					if (raw[2*p] != base_q) begin
						dzc_q <= dt_q[p];
					end else if (ptick[p] && dzc_q != 8'h00) begin
						dzc_q <= dzc_q - 8'h01;
					end
				end
			end
			assign dzo[2*p]   = base_q & (dzc_q == 8'h00);
			assign dzo[2*p+1] = ~base_q & (dzc_q == 8'h00);
			always_comb begin
				if (dz_q[p]) begin
					wave_o[2*p]   = dzo[2*p];
					wave_o[2*p+1] = dzo[2*p+1];
				end else begin
					wave_o[2*p]   = raw[2*p];
					wave_o[2*p+1] = raw[2*p+1];
				end
			end
			a_dz_overlap: assert property (@(posedge clk_i) disable iff (!rstn_i)
				dz_q[p] |-> !(wave_o[2*p] && wave_o[2*p+1]))
				else $error("complementary outputs overlap high");
			a_dz_delay: assert property (@(posedge clk_i) disable iff (!rstn_i)
				dz_q[p] && dt_q[p] != 8'h00 && $rose(raw[2*p]) |=> !dzo[2*p])
				else $error("even output rose without dead time");
		end

		for (genvar c = 0; c < NCH; c++) begin : g_ch
			localparam int P = c / 2;
			logic [3:0] mask;
			// divider: ratio 2^csel, csel codes above 4 saturate at 1/16
			assign mask    = (csel_q[c] > CSEL_MAX) ? 4'hF : 4'((5'h01 << csel_q[c]) - 5'h01);
			assign tick[c] = ptick[P] & ((dv_q[c] & mask) == mask);

			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					dv_q[c] <= DIV_W0;
				end else if (ptick[P]) begin
					dv_q[c] <= dv_q[c] + 4'h1;
				end
			end

			pwg_timer #(.W(W)) u_tmr (
				.clk_i     (clk_i),
				.rstn_i    (rstn_i),
				.en_i      (en_q[c]),
				.tick_i    (tick[c]),
				.auto_i    (auto_q[c]),
				.cap_rld_i (cap_rld[c]),
				.prd_i     (prd_q[c]),
				.cmp_i     (cmp_q[c]),
				.cnt_o     (cnt[c]),
				.zero_o    (zero[c]),
				.wave_o    (raw[c])
			);

			// pin is async: two flops before edge detection
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					c1_q[c] <= 1'b0;
					c2_q[c] <= 1'b0;
					c3_q[c] <= 1'b0;
				end else begin
					c1_q[c] <= cap_i[c];
					c2_q[c] <= c1_q[c];
					c3_q[c] <= c2_q[c];
				end
			end
			assign rise[c]    = cen_q[c] & c2_q[c] & ~c3_q[c];
			assign fall[c]    = cen_q[c] & ~c2_q[c] & c3_q[c];
			assign cap_rld[c] = (rise[c] & rie_q[c]) | (fall[c] & fie_q[c]);
			assign wave_oe_o[c] = ~cen_q[c];

			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					rlat_q[c] <= VAL_RST;
					flat_q[c] <= VAL_RST;
				end else begin
					if (rise[c]) begin
						rlat_q[c] <= cnt[c];
					end
					if (fall[c]) begin
						flat_q[c] <= cnt[c];
					end
				end
			end

			a_cap_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
				rise[c] |=> rlat_q[c] == $past(cnt[c]))
				else $error("rising latch missed counter value");
			a_cap_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
				cap_rld[c] |=> cflag_q[c])
				else $error("capture interrupt flag not set");
			a_period_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
				zero[c] |=> pflag_q[c] ##1 (irq_o || !$past(pie_q[c])))
				else $error("period flag or request missing");
		end
	endgenerate

	// configuration registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			psc_q  <= '0;
			csel_q <= '0;
			en_q   <= '0;
			auto_q <= '0;
			dz_q   <= '0;
			dt_q   <= '0;
			pie_q  <= '0;
			cen_q  <= '0;
			rie_q  <= '0;
			fie_q  <= '0;
		end else if (wr_i) begin
			for (int i = 0; i < NCH; i++) begin
				if (addr_i == OFS_CSEL) begin
					csel_q[i] <= wdata_i[CSEL_ST*i +: CSEL_W];
				end
				if (addr_i == OFS_WCR) begin
					en_q[i]   <= wdata_i[WCR_EN + i];
					auto_q[i] <= wdata_i[WCR_AUTO + i];
				end
				if (addr_i == OFS_PIE) begin
					pie_q[i] <= wdata_i[i];
				end
				if (addr_i == OFS_CCR + 8'(4 * (i / 2))) begin
					cen_q[i] <= wdata_i[CCR_HALF*(i%2) + CCR_CEN];
					rie_q[i] <= wdata_i[CCR_HALF*(i%2) + CCR_RIE];
					fie_q[i] <= wdata_i[CCR_HALF*(i%2) + CCR_FIE];
				end
			end
			for (int p = 0; p < NP; p++) begin
				if (addr_i == OFS_PSC) begin
					psc_q[p] <= wdata_i[8*p +: 8];
				end
				if (addr_i == OFS_DT) begin
					dt_q[p] <= wdata_i[8*p +: 8];
				end
				if (addr_i == OFS_WCR) begin
					dz_q[p] <= wdata_i[WCR_DZ + p];
				end
			end
		end
	end

	// period and compare buffers: the timers pick them up at zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prd_q <= '0;
			cmp_q <= '0;
		end else if (wr_i) begin
			for (int i = 0; i < NCH; i++) begin
				if (addr_i == OFS_PRD + 8'(4 * i)) begin
					prd_q[i] <= wdata_i[W-1:0];
				end
				if (addr_i == OFS_CMP + 8'(4 * i)) begin
					cmp_q[i] <= wdata_i[W-1:0];
				end
			end
		end
	end

	// sticky flags: a set in the clearing cycle wins over the write of one
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pflag_q <= '0;
			cflag_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (zero[i]) begin
					pflag_q[i] <= 1'b1;
				end else if (wr_i && addr_i == OFS_WAVE_IRQ_INDICATION && wdata_i[i]) begin
					pflag_q[i] <= 1'b0;
				end
				if (cap_rld[i]) begin
					cflag_q[i] <= 1'b1;
				end else if (wr_i && addr_i == OFS_WAVE_IRQ_INDICATION && wdata_i[WAVE_IRQ_INDICATION_CAP + i]) begin
					cflag_q[i] <= 1'b0;
				end
			end
		end
	end

	// request: masked period flags, capture flags already gated by their enables
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(pflag_q & pie_q) | (|cflag_q);
		end
	end

	a_irq_mask: assert property (@(posedge clk_i) disable iff (!rstn_i)
		pflag_q == '0 && cflag_q == '0 ##1 pflag_q == '0 && cflag_q == '0 |-> !irq_o)
		else $error("interrupt raised with no flag");
	a_w1c_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_i && addr_i == OFS_WAVE_IRQ_INDICATION && wdata_i[0] && !zero[0] |=> !pflag_q[0])
		else $error("write of one did not clear flag");

	// read mux, answer one cycle after the strobe
	always_comb begin
		rd_d = 32'h0000_0000;
		for (int i = 0; i < NCH; i++) begin
			if (addr_i == OFS_CSEL) begin
				rd_d[CSEL_ST*i +: CSEL_W] = csel_q[i];
			end
			if (addr_i == OFS_WCR) begin
				rd_d[WCR_EN + i]   = en_q[i];
				rd_d[WCR_AUTO + i] = auto_q[i];
			end
			if (addr_i == OFS_PIE) begin
				rd_d[i] = pie_q[i];
			end
			if (addr_i == OFS_WAVE_IRQ_INDICATION) begin
				rd_d[i]            = pflag_q[i];
				rd_d[WAVE_IRQ_INDICATION_CAP + i] = cflag_q[i];
			end
			if (addr_i == OFS_CCR + 8'(4 * (i / 2))) begin
				rd_d[CCR_HALF*(i%2) + CCR_CEN] = cen_q[i];
				rd_d[CCR_HALF*(i%2) + CCR_RIE] = rie_q[i];
				rd_d[CCR_HALF*(i%2) + CCR_FIE] = fie_q[i];
				rd_d[CCR_HALF*(i%2) + CCR_FLG] = cflag_q[i];
			end
			if (addr_i == OFS_PRD + 8'(4 * i)) begin
				rd_d[W-1:0] = prd_q[i];
			end
			if (addr_i == OFS_CMP + 8'(4 * i)) begin
				rd_d[W-1:0] = cmp_q[i];
			end
			if (addr_i == OFS_CNT + 8'(4 * i)) begin
				rd_d[W-1:0] = cnt[i];
			end
			if (addr_i == OFS_RLAT + 8'(4 * i)) begin
				rd_d[W-1:0] = rlat_q[i];
			end
			if (addr_i == OFS_FLAT + 8'(4 * i)) begin
				rd_d[W-1:0] = flat_q[i];
			end
		end
		for (int p = 0; p < NP; p++) begin
			if (addr_i == OFS_PSC) begin
				rd_d[8*p +: 8] = psc_q[p];
			end
			if (addr_i == OFS_DT) begin
				rd_d[8*p +: 8] = dt_q[p];
			end
			if (addr_i == OFS_WCR) begin
				rd_d[WCR_DZ + p] = dz_q[p];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= rd_d;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule : pwg_top

// ===== verification/pwg_pin_model.sv
// pin-level model of the far side: drives capture pins once the device releases them
`timescale 1ns/10ps
module pwg_pin_model (
	input  wire logic [7:0] wave_i,
	input  wire logic [7:0] wave_oe_i,
	input  wire logic [7:0] level_i,
	output logic      [7:0] pin_o
);
	// a driven pin reads back its own level; a released pin carries the outside source
	assign pin_o = (wave_oe_i & wave_i) | (~wave_oe_i & level_i);
endmodule : pwg_pin_model

// ===== verification/pwg_top_test.sv
// self-checking bench for the pwm generator with capture
`timescale 1ns/10ps
module pwg_top_test;
	import pwg_pkg::*;
	localparam logic [7:0] RA [13] = '{OFS_PSC, OFS_CSEL, OFS_WCR, OFS_DT, OFS_PRD, OFS_CMP,
		OFS_CNT, OFS_PIE, OFS_WAVE_IRQ_INDICATION, OFS_CCR, OFS_RLAT, OFS_FLAT, 8'hFC};
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_s  = 1'b0;
	logic        rd_s  = 1'b0;
	logic [7:0]  drv   = 8'h00;
	logic [31:0] rdata, v, rl;
	logic [7:0]  wave, wave_oe, pin;
	logic        irq;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          per, hi, h1, ov, g, gm;

	always #10 clk = ~clk;

	pwg_top pwg_top_inst (.clk_i(clk), .rstn_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .cap_i(pin), .wave_o(wave),
		.wave_oe_o(wave_oe), .irq_o(irq));
	pwg_pin_model pwg_pin_model_inst (.wave_i(wave), .wave_oe_i(wave_oe), .level_i(drv),
		.pin_o(pin));

	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// a hung wait must still reach the verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	// one gap cycle between accesses keeps each strobe to one assignment per edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic cfg(input int c, input int ps, input int cs, input logic [15:0] pr,
		input logic [15:0] cm, input logic [31:0] w);
		wr(OFS_WCR, 32'h0);
		wr(OFS_PSC, 32'(ps) << (8 * (c / 2)));
		wr(OFS_CSEL, 32'(cs) << (4 * c));
		wr(OFS_PRD + 8'(4 * c), {16'h0000, pr});
		wr(OFS_CMP + 8'(4 * c), {16'h0000, cm});
		wr(OFS_WCR, w);
	endtask : cfg

	// rise-to-rise period and high time of one output, in clocks
	task automatic meas(input int c, output int p_out, output int h_out);
		logic p;
		int   n;
		n = 0;
		p = 1'b1;
		while (!(p === 1'b0 && wave[c] === 1'b1) && n < 3000) begin
			p = wave[c];
			step;
			n++;
		end
		p_out = 0;
		h_out = 0;
		do begin
			if (wave[c] === 1'b1) h_out++;
			p = wave[c];
			step;
			p_out++;
		end while (!(p === 1'b0 && wave[c] === 1'b1) && p_out < 3000);
	endtask : meas

	initial begin
		idle(5);
		rst_n <= 1'b1;
		step;
		chk(wave_oe, 8'hFF);
		chk(irq, 0);
		foreach (RA[i]) begin
			rd(RA[i], v);
			chk(v, 32'h0);
		end
		wr(OFS_CNT, 32'h55);
		rd(OFS_CNT, v);
		chk(v, 32'h0);
		// tick is (prescale+1) clocks times the divider; 5 and above act as 1/16
		for (int cs = 0; cs < 6; cs++) begin
			cfg(0, 2, cs, 16'h0003, 16'h0001, 32'h101);
			meas(0, per, hi);
			meas(0, per, hi);
			chk(per, 12 << (cs > 4 ? 4 : cs));
		end
		wr(OFS_WCR, 32'h0);
		rd(OFS_CNT, rl);
		idle(20);
		rd(OFS_CNT, v);
		chk(v, rl);
		cfg(0, 2, 0, 16'h0003, 16'h0001, 32'h101);
		meas(0, per, hi);
		wr(OFS_PRD, 32'h7);
		rd(OFS_CNT, v);
		chk(v <= 32'h3, 1);
		meas(0, per, hi);
		chk(per, 24);
		h1 = hi;
		wr(OFS_CMP, 32'h3);
		meas(0, per, hi);
		meas(0, per, hi);
		chk(hi - h1, 6);
		wr(OFS_WCR, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(OFS_PRD + 8'(4 * c), 32'h2);
			wr(OFS_CMP + 8'(4 * c), 32'h1);
		end
		wr(OFS_CSEL, 32'h0);
		wr(OFS_PSC, 32'h0);
		wr(OFS_PIE, 32'h0);
		wr(OFS_WAVE_IRQ_INDICATION, 32'hFFFF);
		wr(OFS_WCR, 32'hFF);
		idle(30);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[7:0], 8'hFF);
		chk(irq, 0);
		rd(OFS_CNT + 8'hC, v);
		chk(v, 32'h0);
		wr(OFS_WAVE_IRQ_INDICATION, 32'hFF);
		idle(30);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[7:0], 8'h00);
		wr(OFS_PIE, 32'h2);
		wr(OFS_WCR, 32'h0);
		wr(OFS_WCR, 32'h2);
		idle(19);
		step;
		chk(irq, 1);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[7:0], 8'h02);
		wr(OFS_WAVE_IRQ_INDICATION, 32'h2);
		idle(1);
		step;
		chk(irq, 0);
		wr(OFS_DT, 32'h3);
		cfg(0, 0, 0, 16'h0009, 16'h0004, 32'h10101);
		idle(30);
		ov = 0;
		g = 0;
		gm = 0;
		h1 = 0;
		repeat (200) begin
			step;
			if (wave[0] & wave[1]) ov++;
			if (wave[1]) h1++;
			if (!wave[0] && !wave[1]) g++;
			else begin
				if (g > gm) gm = g;
				g = 0;
			end
		end
		chk(ov, 0);
		chk(gm, 3);
		chk(h1 > 0, 1);
		wr(OFS_WAVE_IRQ_INDICATION, 32'hFFFF);
		wr(OFS_PIE, 32'h0);
		// timer fully set up before capture is switched on
		cfg(2, 0, 0, 16'h0FFF, 16'h0000, 32'h0404);
		wr(OFS_CCR + 8'h4, 32'h7);
		step;
		chk(wave_oe, 8'hFB);
		idle(500);
		drv <= 8'h04;
		idle(10);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[10], 1);
		chk(irq, 1);
		rd(OFS_RLAT + 8'h8, rl);
		chk(rl > 32'hC00 && rl < 32'hF00, 1);
		rd(OFS_CNT + 8'h8, v);
		chk(v > 32'hFC0, 1);
		wr(OFS_WAVE_IRQ_INDICATION, 32'h400);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[10], 0);
		idle(1);
		// the pin only moves once the flag has been serviced
		drv <= 8'h00;
		idle(10);
		rd(OFS_FLAT + 8'h8, v);
		chk(v > 32'hF80 && v <= 32'hFFF, 1);
		rd(OFS_RLAT + 8'h8, v);
		chk(v, rl);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[10], 1);
		cfg(0, 0, 0, 16'h0FFF, 16'h0000, 32'h0);
		cfg(1, 0, 0, 16'h0FFF, 16'h0000, 32'h0303);
		wr(OFS_CCR, 32'h0003_0005);
		idle(8);
		wr(OFS_WAVE_IRQ_INDICATION, 32'hFFFF);
		idle(1);
		drv <= 8'h03;
		idle(10);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[9:8], 2'h2);
		wr(OFS_WAVE_IRQ_INDICATION, 32'hFFFF);
		idle(1);
		drv <= 8'h00;
		idle(10);
		rd(OFS_WAVE_IRQ_INDICATION, v);
		chk(v[9:8], 2'h1);
		report_and_stop;
	end
endmodule : pwg_top_test
